// file: verilog/cai_alu.sv
// Operation
// RQ1 - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// RQ2 - Destination bit 0 writes accumulator, 1 writes the addressed file register.
// RQ3 - Subtract-from-literal: literal minus accumulator into accumulator; carry, digit-carry, zero.
// RQ4 - Carry and digit-carry are 0 on borrow out of byte or nibble.
// RQ5 - Subtract-from-file: file minus accumulator, routed by destination, flags updated.
// RQ6 - Subtract-with-borrow also subtracts inverted carry; routed by destination.
// RQ7 - Sleep clears watchdog counter and prescaler.
// RQ8 - Sleep clears power-down status, sets time-out status, nothing else.
// RQ9 - Sleep then halts the oscillator until wake.
// RQ10 - Nibble swap exchanges halves, routed by destination, no flags touched.
// RQ11 - Literal XOR into accumulator, only zero flag updated.
// RQ12 - Direction load copies accumulator to port A, B or C for 5, 6, 7.
// RQ13 - File XOR routed by destination, only zero flag updated.
// RQ14 - Zero flag set when the 8-bit result is zero, else cleared.
// RQ15 - Direction-load operands outside 5 to 7 change no direction register.
`timescale 1ns/1ps
module cai_alu
  import cai_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wake pin, asynchronous, active low
  input wire logic wake_n,
  // Port direction and power state
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  output logic osc_halt
);

  cai_state_s st_ff;
  cai_state_s nxt_st;

  logic access;
  logic hit;
  logic exec;
  cai_op_e op;
  logic dest;
  logic [7:0] opnd;
  logic [6:0] faddr;
  logic [7:0] fval;
  logic [7:0] minuend;
  logic borrow;
  logic [8:0] diff9;
  logic [4:0] diff5;
  logic [7:0] result;
  logic routed;
  logic [31:0] rd_word;

  // Bus decode; the slave never inserts wait states
  assign access = psel & penable;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata = st_ff.prdata;

  always_comb begin
    unique case (paddr)
      ADDR_CMD, ADDR_ACC, ADDR_STATUS, ADDR_DIR_A, ADDR_DIR_B,
      ADDR_DIR_C, ADDR_FPTR, ADDR_FDATA, ADDR_WDOG: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Command fields; a halted core ignores commands
  assign exec = access & pwrite & (paddr == ADDR_CMD) & ~st_ff.sleeping;
  assign op = cai_op_e'(pwdata[OP_LSB +: OP_W]);
  assign dest = pwdata[DEST_BIT];
  assign opnd = pwdata[OPND_LSB +: 8];
  assign faddr = opnd[6:0];
  assign fval = st_ff.file[faddr];

  // Shared subtractor; a nine-bit and five-bit difference expose both borrows
  assign minuend = (op == op_sub_literal) ? opnd : fval;
  assign borrow = (op == op_sub_borrow) ? ~st_ff.carry : 1'b0; // see RQ6
  assign diff9 = {1'b0, minuend} - {1'b0, st_ff.acc} - {8'h00, borrow};
  assign diff5 = {1'b0, minuend[3:0]} - {1'b0, st_ff.acc[3:0]} - {4'h0, borrow};

  // Result of the current instruction
  always_comb begin
    result = 8'h00;
    routed = 1'b0;
    unique case (op)
      op_rotate_right: begin
        result = {st_ff.carry, fval[7:1]}; // see RQ1
        routed = 1'b1;
      end
      op_sub_file, op_sub_borrow: begin
        result = diff9[7:0]; // see RQ5
        routed = 1'b1;
      end
      op_sub_literal: result = diff9[7:0]; // see RQ3
      op_nibble_swap: begin
        result = {fval[3:0], fval[7:4]}; // see RQ10
        routed = 1'b1;
      end
      op_xor_literal: result = st_ff.acc ^ opnd; // see RQ11
      op_xor_file: begin
        result = st_ff.acc ^ fval; // see RQ13
        routed = 1'b1;
      end
      default: result = 8'h00;
    endcase
  end

  // Read data, captured in the setup cycle so it is stable in the access cycle
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      ADDR_ACC: rd_word[7:0] = st_ff.acc;
      ADDR_STATUS: begin
        rd_word[ST_C] = st_ff.carry;
        rd_word[ST_DIGIT] = st_ff.digit_carry_flag;
        rd_word[ST_Z] = st_ff.zero;
        rd_word[ST_PWRDN] = st_ff.powerdown_status_n;
        rd_word[ST_TMOUT] = st_ff.timeout_status_n;
      end
      ADDR_DIR_A: rd_word[7:0] = st_ff.port_a_direction;
      ADDR_DIR_B: rd_word[7:0] = st_ff.port_b_direction;
      ADDR_DIR_C: rd_word[7:0] = st_ff.port_c_direction;
      ADDR_FPTR: rd_word[6:0] = st_ff.fptr;
      ADDR_FDATA: rd_word[7:0] = st_ff.file[st_ff.fptr];
      ADDR_WDOG: begin
        rd_word[WDOG_CNT_LSB +: 8] = st_ff.watchdog_counter;
        rd_word[WDOG_PRE_LSB +: 8] = st_ff.presc;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Next state
  always_comb begin
    nxt_st = st_ff;
    // Wake pin synchroniser, first stage feeds only the second
    nxt_st.wake_meta = wake_n;
    nxt_st.wake_sync = st_ff.wake_meta;
    if (psel & ~penable & ~pwrite) begin
      nxt_st.prdata = rd_word;
    end
    // Watchdog runs only while the oscillator does
    if (~st_ff.sleeping) begin
      nxt_st.presc = st_ff.presc + 8'h01;
      if (st_ff.presc == PRESC_TOP) begin
        nxt_st.watchdog_counter = st_ff.watchdog_counter + 8'h01;
      end
    end else if (~st_ff.wake_sync) begin
      nxt_st.sleeping = 1'b0;
    end
    // Plain register writes from software
    if (access & pwrite) begin
      unique case (paddr)
        ADDR_ACC: nxt_st.acc = pwdata[7:0];
        ADDR_STATUS: begin
          nxt_st.carry = pwdata[ST_C];
          nxt_st.digit_carry_flag = pwdata[ST_DIGIT];
          nxt_st.zero = pwdata[ST_Z];
        end
        ADDR_FPTR: nxt_st.fptr = pwdata[6:0];
        ADDR_FDATA: nxt_st.file[st_ff.fptr] = pwdata[7:0];
        default: nxt_st.fptr = st_ff.fptr;
      endcase
    end
    // Instruction execution
    if (exec) begin
      if (routed & dest) begin
        nxt_st.file[faddr] = result; // see RQ2
      end else if (routed | (op == op_sub_literal) | (op == op_xor_literal)) begin
        nxt_st.acc = result; // see RQ2
      end
      if (op == op_rotate_right) begin
        nxt_st.carry = fval[0]; // see RQ1
      end
      if ((op == op_sub_literal) | (op == op_sub_file) | (op == op_sub_borrow)) begin
        nxt_st.carry = ~diff9[8]; // see RQ4
        nxt_st.digit_carry_flag = ~diff5[4]; // see RQ4
      end
      if ((op == op_sub_literal) | (op == op_sub_file) | (op == op_sub_borrow)
          | (op == op_xor_literal) | (op == op_xor_file)) begin
        nxt_st.zero = (result == 8'h00); // see RQ14
      end
      if (op == op_dir_load) begin
        // Other operands fall through untouched, see RQ15
        if (opnd == DIR_SEL_A) nxt_st.port_a_direction = st_ff.acc; // see RQ12
        if (opnd == DIR_SEL_B) nxt_st.port_b_direction = st_ff.acc; // see RQ12
        if (opnd == DIR_SEL_C) nxt_st.port_c_direction = st_ff.acc; // see RQ12
      end
      if (op == op_sleep) begin
        nxt_st.watchdog_counter = 8'h00; // see RQ7
        nxt_st.presc = 8'h00; // see RQ7
        nxt_st.powerdown_status_n = 1'b0; // see RQ8
        nxt_st.timeout_status_n = 1'b1; // see RQ8
        nxt_st.sleeping = 1'b1; // see RQ9
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flops
  assign port_a_direction = st_ff.port_a_direction;
  assign port_b_direction = st_ff.port_b_direction;
  assign port_c_direction = st_ff.port_c_direction;
  assign osc_halt = st_ff.sleeping; // see RQ9

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rotate_carry: assert property (exec && op == op_rotate_right // see RQ1
    |=> st_ff.carry == $past(fval[0])) else $error("rotate carry wrong");
  a_dest_file: assert property (exec && routed && dest // see RQ2
    |=> st_ff.file[$past(faddr)] == $past(result) && $stable(st_ff.acc))
    else $error("file destination wrong");
  a_sub_literal_acc: assert property (exec && op == op_sub_literal // see RQ3
    |=> st_ff.acc == $past(opnd) - $past(st_ff.acc)) else $error("literal subtract wrong");
  a_sub_carry_out: assert property (exec && (op == op_sub_file || op == op_sub_literal) // see RQ4
    |=> st_ff.carry == ($past(minuend) >= $past(st_ff.acc))) else $error("borrow flag wrong");
  a_sub_file_acc: assert property (exec && op == op_sub_file && !dest // see RQ5
    |=> st_ff.acc == $past(fval) - $past(st_ff.acc)) else $error("file subtract wrong");
  a_sub_borrow_in: assert property (exec && op == op_sub_borrow && !st_ff.carry && !dest // see RQ6
    |=> st_ff.acc == $past(fval) - $past(st_ff.acc) - 8'h01) else $error("borrow in wrong");
  a_sleep_watchdog: assert property (exec && op == op_sleep // see RQ7
    |=> st_ff.watchdog_counter == 8'h00 && st_ff.presc == 8'h00) else $error("watchdog not cleared");
  a_sleep_status: assert property (exec && op == op_sleep // see RQ8
    |=> !st_ff.powerdown_status_n && st_ff.timeout_status_n && $stable(st_ff.zero))
    else $error("sleep status wrong");
  a_sleep_halt: assert property (exec && op == op_sleep // see RQ9
    |=> osc_halt ##1 (osc_halt || !$past(st_ff.wake_sync))) else $error("oscillator not halted");
  a_swap_flags: assert property (exec && op == op_nibble_swap // see RQ10
    |=> $stable(st_ff.carry) && $stable(st_ff.zero)) else $error("swap touched flags");
  a_xor_literal_acc: assert property (exec && op == op_xor_literal // see RQ11
    |=> st_ff.acc == ($past(opnd) ^ $past(st_ff.acc)) && $stable(st_ff.carry))
    else $error("literal xor wrong");
  a_dir_load_a: assert property (exec && op == op_dir_load && opnd == DIR_SEL_A // see RQ12
    |=> port_a_direction == $past(st_ff.acc)) else $error("direction load wrong");
  a_xor_file_flags: assert property (exec && op == op_xor_file // see RQ13
    |=> $stable(st_ff.carry) && $stable(st_ff.digit_carry_flag)) else $error("xor touched carry");
  a_zero_flag: assert property (exec && op == op_xor_file && !dest // see RQ14
    |=> st_ff.zero == (st_ff.acc == 8'h00)) else $error("zero flag wrong");
  a_dir_bad_operand: assert property (exec && op == op_dir_load // see RQ15
    && (opnd < DIR_SEL_A || opnd > DIR_SEL_C)
    |=> $stable(port_a_direction) && $stable(port_b_direction) && $stable(port_c_direction))
    else $error("direction changed on bad operand");

  // Results and flags of the remaining cases, and the halted core
  a_rotate_result: assert property (exec && op == op_rotate_right && !dest // see RQ1
    |=> st_ff.acc == {$past(st_ff.carry), $past(fval[7:1])})
    else $error("rotate result wrong");
  a_rotate_flags: assert property (exec && op == op_rotate_right // see RQ1
    |=> $stable(st_ff.zero) && $stable(st_ff.digit_carry_flag))
    else $error("rotate touched flags");
  a_dest_acc: assert property (exec && routed && !dest // see RQ2
    |=> st_ff.acc == $past(result))
    else $error("accumulator destination wrong");
  a_sub_digit: assert property (exec && (op == op_sub_file || op == op_sub_literal) // see RQ4
    |=> st_ff.digit_carry_flag == ($past(minuend[3:0]) >= $past(st_ff.acc[3:0])))
    else $error("digit borrow flag wrong");
  a_borrow_carry: assert property (exec && op == op_sub_borrow // see RQ6
    |=> st_ff.carry == ({1'b0, $past(fval)}
    >= {1'b0, $past(st_ff.acc)} + {8'h00, ~$past(st_ff.carry)}))
    else $error("borrow chain carry wrong");
  a_swap_result: assert property (exec && op == op_nibble_swap && !dest // see RQ10
    |=> st_ff.acc == {$past(fval[3:0]), $past(fval[7:4])})
    else $error("swap result wrong");
  a_xor_file_dest: assert property (exec && op == op_xor_file && dest // see RQ13
    |=> st_ff.file[$past(faddr)] == ($past(fval) ^ $past(st_ff.acc)))
    else $error("file xor wrong");
  a_xor_lit_zero: assert property (exec && op == op_xor_literal // see RQ11
    |=> st_ff.zero == (st_ff.acc == 8'h00) && $stable(st_ff.digit_carry_flag))
    else $error("literal xor flags wrong");
  a_dir_load_b: assert property (exec && op == op_dir_load && opnd == DIR_SEL_B // see RQ12
    |=> port_b_direction == $past(st_ff.acc))
    else $error("direction load wrong");
  a_dir_load_c: assert property (exec && op == op_dir_load && opnd == DIR_SEL_C // see RQ12
    |=> port_c_direction == $past(st_ff.acc))
    else $error("direction load wrong");
  a_sleep_frozen: assert property (st_ff.sleeping // see RQ9
    |=> $stable(st_ff.watchdog_counter) && $stable(st_ff.presc))
    else $error("watchdog ran while halted");
  a_halt_ignores: assert property (st_ff.sleeping && access && pwrite // see RQ9
    && paddr == ADDR_CMD |=> $stable(st_ff.acc) && $stable(st_ff.zero))
    else $error("command ran while halted");
  a_sleep_flags: assert property (exec && op == op_sleep // see RQ8
    |=> $stable(st_ff.carry) && $stable(st_ff.digit_carry_flag))
    else $error("sleep touched flags");
  a_zero_sub: assert property (exec && !dest // see RQ14
    && (op == op_sub_file || op == op_sub_borrow) |=> st_ff.zero == (st_ff.acc == 8'h00))
    else $error("subtract zero flag wrong");

  c_sleep_wake: cover property (osc_halt ##[1:20] !osc_halt);
  c_sub_borrow: cover property (exec && op == op_sub_borrow && !st_ff.carry);
  c_dir_load: cover property (exec && op == op_dir_load && opnd == DIR_SEL_C);
  c_rotate_file: cover property (exec && op == op_rotate_right && dest);
  c_bus_error: cover property (access && !hit);

endmodule // cai_alu

// file: verilog/cai_pkg.sv
package cai_pkg;

  // Register byte offsets on the APB window
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DIR_A = 8'h0c;
  localparam logic [7:0] ADDR_DIR_B = 8'h10;
  localparam logic [7:0] ADDR_DIR_C = 8'h14;
  localparam logic [7:0] ADDR_FPTR = 8'h18;
  localparam logic [7:0] ADDR_FDATA = 8'h1c;
  localparam logic [7:0] ADDR_WDOG = 8'h20;

  // Command word layout
  localparam int OP_LSB = 0;
  localparam int OP_W = 4;
  localparam int DEST_BIT = 4;
  localparam int OPND_LSB = 8;

  // Status register bit positions
  localparam int ST_C = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_Z = 2;
  localparam int ST_PWRDN = 3;
  localparam int ST_TMOUT = 4;

  // Watchdog fields inside the read word
  localparam int WDOG_CNT_LSB = 0;
  localparam int WDOG_PRE_LSB = 8;
  localparam logic [7:0] PRESC_TOP = 8'hff;

  // Direction-load operand codes
  localparam logic [7:0] DIR_SEL_A = 8'h05;
  localparam logic [7:0] DIR_SEL_B = 8'h06;
  localparam logic [7:0] DIR_SEL_C = 8'h07;
  localparam logic [7:0] DIR_RST = 8'hff;

  // Instruction codes carried in the command word
  typedef enum logic [3:0] {
    op_nop = 4'h0,
    op_rotate_right = 4'h1,
    op_sub_literal = 4'h2,
    op_sub_file = 4'h3,
    op_sub_borrow = 4'h4,
    op_nibble_swap = 4'h5,
    op_xor_literal = 4'h6,
    op_xor_file = 4'h7,
    op_dir_load = 4'h8,
    op_sleep = 4'h9
  } cai_op_e;

  // Whole state of the block
  typedef struct packed {
    logic [127:0][7:0] file;
    logic [7:0] acc;
    logic carry;
    logic digit_carry_flag;
    logic zero;
    logic powerdown_status_n;
    logic timeout_status_n;
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] port_c_direction;
    logic sleeping;
    logic [7:0] watchdog_counter;
    logic [7:0] presc;
    logic [6:0] fptr;
    logic [31:0] prdata;
    logic wake_meta;
    logic wake_sync;
  } cai_state_s;

  localparam cai_state_s ST_RST = '{
    powerdown_status_n: 1'b1,
    timeout_status_n: 1'b1,
    port_a_direction: DIR_RST,
    port_b_direction: DIR_RST,
    port_c_direction: DIR_RST,
    wake_meta: 1'b1,
    wake_sync: 1'b1,
    default: '0
  };

endpackage

// file: tb/test_core_alu_instr_subset.sv
`timescale 1ns/1ps
module test_core_alu_instr_subset;
  import cai_pkg::*;
  // Bus, wake pin and observed outputs
  logic pclk, presetn, psel, penable, pwrite, wake_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, osc_halt;
  logic [7:0] dir_a, dir_b, dir_c;
  // Expected read words, oldest first; bit 32 is the expected error flag
  logic [32:0] exp_q[$];
  int error_cnt, cmp_count, cyc;
  // Reference state kept by the driver
  logic [7:0] w, f, k, r, ea, eb, ec;
  logic c, dcf, z, pdn, ton, dest;
  logic [6:0] fa;
  logic [8:0] d9;
  logic [4:0] d5;
  cai_op_e op;

  cai_alu u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_n(wake_n), .port_a_direction(dir_a), .port_b_direction(dir_b),
    .port_c_direction(dir_c), .osc_halt(osc_halt)
  );

  // Free running clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic cmd(input cai_op_e o, input logic dst, input logic [7:0] opnd);
    apb(1'b1, ADDR_CMD, {16'h0, opnd, 3'h0, dst, o});
  endtask

  function automatic logic [31:0] stw();
    return {27'h0, ton, pdn, z, dcf, c};
  endfunction

  // Reference subtraction a - b - borrow, flags as no-borrow indicators
  task automatic sub(input logic [7:0] a, input logic [7:0] b, input logic bin);
    d9 = {1'b0, a} - {1'b0, b} - {8'h0, bin};
    d5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
    r = d9[7:0];
    c = ~d9[8];
    dcf = ~d5[4];
  endtask

  // Read monitor: compares each access-phase read with the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1) begin
      cmp_count++;
      if (exp_q.size() == 0 || {pslverr, prdata} !== exp_q[0]) begin
        error_cnt++;
        $display("unexpected read at %0t: addr %h got %h", $time, paddr, {pslverr, prdata});
      end
      if (exp_q.size() != 0)
        void'(exp_q.pop_front());
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    wake_n = 1'b1;
    presetn = 1'b0;
    {c, dcf, z, w} = '0;
    {pdn, ton} = 2'b11;
    {ea, eb, ec} = {3{8'hff}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'h83c64f3a));
    rd(ADDR_ACC, 32'h0, 1'b0);
    rd(ADDR_STATUS, stw(), 1'b0);
    for (int j = 0; j < 3; j++)
      rd(ADDR_DIR_A + 8'(4 * j), 32'hff, 1'b0);
    // Operation codes 1 to 8 in turn with random operands and destination
    for (int i = 0; i < 160; i++) begin
      op = cai_op_e'(4'(1 + i % 8));
      dest = 1'($urandom_range(0, 1));
      fa = 7'($urandom_range(0, 127));
      w = 8'($urandom);
      f = ($urandom_range(0, 3) == 0) ? w : 8'($urandom);
      k = (op inside {op_sub_literal, op_xor_literal}) ? f : {1'b0, fa};
      if (op == op_dir_load)
        k = 8'($urandom_range(4, 8));
      {z, dcf, c} = 3'($urandom);
      apb(1'b1, ADDR_ACC, {24'h0, w});
      apb(1'b1, ADDR_STATUS, stw());
      apb(1'b1, ADDR_FPTR, {25'h0, fa});
      apb(1'b1, ADDR_FDATA, {24'h0, f});
      cmd(op, dest, k);
      r = w;
      case (op)
        op_rotate_right: begin
          r = {c, f[7:1]};
          c = f[0];
        end
        op_sub_literal: sub(k, w, 1'b0);
        op_sub_file: sub(f, w, 1'b0);
        op_sub_borrow: sub(f, w, ~c);
        op_nibble_swap: r = {f[3:0], f[7:4]};
        op_xor_literal: r = w ^ k;
        op_xor_file: r = w ^ f;
        default: begin
          // Operands other than 5 to 7 leave every direction alone
          if (k == 8'h05) ea = w;
          if (k == 8'h06) eb = w;
          if (k == 8'h07) ec = w;
        end
      endcase
      if (op inside {op_sub_literal, op_sub_file, op_sub_borrow, op_xor_literal, op_xor_file})
        z = (r == 8'h00);
      if (op inside {op_sub_literal, op_xor_literal} || (op != op_dir_load && !dest))
        w = r;
      else if (op != op_dir_load)
        f = r;
      rd(ADDR_ACC, {24'h0, w}, 1'b0);
      rd(ADDR_STATUS, stw(), 1'b0);
      rd(ADDR_FDATA, {24'h0, f}, 1'b0);
      if (op == op_dir_load) begin
        rd(ADDR_DIR_A, {24'h0, ea}, 1'b0);
        rd(ADDR_DIR_B, {24'h0, eb}, 1'b0);
        rd(ADDR_DIR_C, {24'h0, ec}, 1'b0);
        cmp_count++;
        if ({dir_a, dir_b, dir_c} !== {ea, eb, ec}) begin
          error_cnt++;
          $display("unexpected direction outputs at %0t", $time);
        end
      end
    end
    // Direction registers are read-only from the bus; holes report an error
    apb(1'b1, ADDR_DIR_A, 32'h0);
    rd(ADDR_DIR_A, {24'h0, ea}, 1'b0);
    rd(8'h24, 32'h0, 1'b1);
    // Sleep: status bits, watchdog cleared, commands ignored while halted
    {z, dcf, c} = 3'b101;
    apb(1'b1, ADDR_STATUS, stw());
    cmd(op_sleep, 1'b0, 8'h00);
    pdn = 1'b0;
    ton = 1'b1;
    rd(ADDR_STATUS, stw(), 1'b0);
    rd(ADDR_WDOG, 32'h0, 1'b0);
    cmd(op_xor_literal, 1'b0, 8'h5a);
    rd(ADDR_ACC, {24'h0, w}, 1'b0);
    cmp_count++;
    if (osc_halt !== 1'b1) begin
      error_cnt++;
      $display("unexpected oscillator still running at %0t", $time);
    end
    @(posedge pclk);
    wake_n <= 1'b0;
    for (int j = 0; j < 8 && osc_halt !== 1'b0; j++)
      @(posedge pclk);
    wake_n <= 1'b1;
    cmp_count++;
    if (osc_halt !== 1'b0) begin
      error_cnt++;
      $display("unexpected oscillator still halted at %0t", $time);
    end
    cmd(op_xor_literal, 1'b0, 8'h5a);
    w = w ^ 8'h5a;
    rd(ADDR_ACC, {24'h0, w}, 1'b0);
    repeat (2) @(posedge pclk);
    close_out();
  end
endmodule // test_core_alu_instr_subset
